// ---- safe_stop_one_sequencer.sv ----
// Monitored stop sequencer with an AXI4-Lite register file.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "safe_stop_one_params.svh"
module safe_stop_one_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        stop_request,
  input  wire logic        stop_ack,
  input  wire logic [15:0] motor_speed,
  output logic             safe_torque_removal,
  output logic             safe_brake_control,
  output logic             stop_active_indication,
  output logic             stop_completed_indication,
  output logic             torque_off_active_indication,
  output logic [15:0]      stop_ramp_param_set,
  output logic             irq
);
  import safe_stop_one_pkg::*;

  seq_regs_t         q;
  seq_regs_t         n;
  delay_timer_if     tif ();
  logic [`TMR_N-1:0] tstart;
  logic [`IRQ_W-1:0] ev;
  logic [`IRQ_W-1:0] clr;
  logic [31:0]       brake_mag;
  logic [31:0]       rd;
  logic [1:0]        rr;
  logic              rd_ok;
  logic              wr_ok;
  logic              zero_spd;
  logic              inter_spd;
  logic              timeout;
  logic              ramp_viol;
  logic              brake_en;
  logic              brake_neg;
  logic [31:0]       ctrl_wr;
  logic [31:0]       msk_wr;

  // Maps a byte address to a configuration slot; flags anything outside the slots.
  function automatic logic [4:0] cfg_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - `OFS_CFG_BASE;
    if (addr < `OFS_CFG_BASE || addr > `OFS_CFG_LAST || addr[1:0] != 2'h0)
      cfg_index = 5'h1F;
    else
      cfg_index = off[6:2];
  endfunction : cfg_index

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (data & m);
  endfunction : merge

  delay_timer_bank u_timers (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tif     (tif)
  );

  // Speed comparisons and supervision conditions.
  assign brake_en  = q.ctrl[`CTRL_BRAKE_EN];
  assign brake_neg = q.cfg[`CFG_BRAKE_DLY][31];
  assign brake_mag = ~q.cfg[`CFG_BRAKE_DLY] + 32'h0000_0001;
  assign zero_spd  = q.ctrl[`CTRL_ENCODER] ?
                     (motor_speed <= q.cfg[`CFG_ENC_ZERO][15:0]) :
                     (motor_speed <= q.cfg[`CFG_ZERO_LIM][15:0]);
  assign inter_spd = brake_en && q.ctrl[`CTRL_INTER_EN] &&
                     (motor_speed <= q.cfg[`CFG_INTER_SPD][15:0]);
  assign timeout   = !q.ctrl[`CTRL_RAMP_MODE] && tif.done[`TMR_MAX];
  assign ramp_viol = q.ctrl[`CTRL_RAMP_MODE] && q.ramp_run &&
                     ({16'h0000, motor_speed} > q.ramp_lim);

  // Timer loads, top slot first; the phase timer carries extra delay, then brake lead.
  assign tif.start = tstart;
  assign tif.load  = {q.cfg[`CFG_RESP_TIME], q.cfg[`CFG_COMPL_DLY],
                      ((q.st == ST_EXTRA) ? brake_mag : q.cfg[`CFG_EXTRA_DLY]),
                      q.cfg[`CFG_MAX_STOP]};

  // Write data merged under the byte strobes for the narrow registers.
  assign ctrl_wr = merge({28'h0000000, q.ctrl}, q.w_data, q.w_strb);
  assign msk_wr  = merge({28'h0000000, q.irq_msk}, q.w_data, q.w_strb);

  // Register read decode.
  always_comb
  begin
    rd    = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL:       rd = {28'h0000000, q.ctrl};
      `OFS_STATUS:     rd = {26'h0000000, q.ramp_run, q.fault, q.brake, q.torque,
                             q.completed, q.active};
      `OFS_IRQ_STATUS: rd = {28'h0000000, q.irq_st};
      `OFS_IRQ_MASK:   rd = {28'h0000000, q.irq_msk};
      default:
      begin
        if (cfg_index(s_axi_araddr) < 5'(`CFG_N))
          rd = q.cfg[cfg_index(s_axi_araddr)];
        else
          rd_ok = 1'b0;
      end
    endcase
    rr = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
  end

  // Bus handshakes, register writes and the stop sequence.
  always_comb
  begin
    n      = q;
    tstart = '0;
    ev     = '0;
    clr    = '0;
    wr_ok  = 1'b1;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && q.awready)
    begin
      n.aw_addr = s_axi_awaddr;
      n.aw_got  = 1'b1;
    end
    if (s_axi_wvalid && q.wready)
    begin
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
      n.w_got  = 1'b1;
    end
    if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;

    // Both halves held and no response pending: perform the write.
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      case (q.aw_addr)
        `OFS_CTRL:       n.ctrl = ctrl_wr[`CTRL_W-1:0];
        `OFS_STATUS:     wr_ok = 1'b1;
        `OFS_IRQ_STATUS: clr = q.w_data[`IRQ_W-1:0] & {`IRQ_W{q.w_strb[0]}};
        `OFS_IRQ_MASK:   n.irq_msk = msk_wr[`IRQ_W-1:0];
        default:
        begin
          if (cfg_index(q.aw_addr) < 5'(`CFG_N))
            n.cfg[cfg_index(q.aw_addr)] = merge(q.cfg[cfg_index(q.aw_addr)],
                                                q.w_data, q.w_strb);
          else
            wr_ok = 1'b0;
        end
      endcase
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end

    // Reads: one outstanding, answered the cycle after the address is taken.
    if (q.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata  = rd;
      n.rresp  = rr;
    end

    // Stop sequence.
    case (q.st)
      ST_IDLE:
      begin
        if (stop_request)
        begin
          n.st       = ST_RAMP;
          n.active   = 1'b1;
          n.fault    = 1'b0;
          n.ramp_run = 1'b0;
          n.ramp_lim = {16'h0000, motor_speed} + q.cfg[`CFG_RAMP_TOL];
          tstart[`TMR_MAX]  = 1'b1;
          tstart[`TMR_RESP] = 1'b1;
          ev[`IRQ_START]    = 1'b1;
        end
      end
      ST_RAMP:
      begin
        // The envelope starts falling once the drive's response time is over.
        if (tif.done[`TMR_RESP])
          n.ramp_run = 1'b1;
        if (q.ramp_run)
          n.ramp_lim = (q.ramp_lim > q.cfg[`CFG_RAMP_STEP]) ?
                       (q.ramp_lim - q.cfg[`CFG_RAMP_STEP]) : 32'h0000_0000;
        if (ramp_viol || timeout)
        begin
          n.st         = ST_COAST;
          n.torque     = 1'b1;
          n.tof_active = 1'b1;
          n.brake      = brake_en;
          n.fault      = 1'b1;
          n.ramp_run   = 1'b0;
          tstart[`TMR_COMPL] = brake_en;
          ev[`IRQ_FAULT]     = 1'b1;
          ev[`IRQ_TORQUE]    = 1'b1;
        end
        else if (zero_spd || inter_spd)
        begin
          n.st       = ST_EXTRA;
          n.ramp_run = 1'b0;
          tstart[`TMR_PHASE] = 1'b1;
        end
      end
      ST_EXTRA:
      begin
        if (timeout)
        begin
          n.st         = ST_COAST;
          n.torque     = 1'b1;
          n.tof_active = 1'b1;
          n.brake      = brake_en;
          tstart[`TMR_COMPL] = brake_en;
          ev[`IRQ_TORQUE]    = 1'b1;
        end
        else if (tif.done[`TMR_PHASE] && brake_en && brake_neg)
        begin
          n.st  = ST_BRAKE;
          n.brake = 1'b1;
          tstart[`TMR_PHASE] = 1'b1;
          tstart[`TMR_COMPL] = 1'b1;
        end
        else if (tif.done[`TMR_PHASE])
        begin
          n.st         = ST_COAST;
          n.torque     = 1'b1;
          n.tof_active = 1'b1;
          n.brake      = brake_en;
          tstart[`TMR_COMPL] = brake_en;
          ev[`IRQ_TORQUE]    = 1'b1;
        end
      end
      ST_BRAKE:
      begin
        if (tif.done[`TMR_PHASE] || timeout)
        begin
          n.st         = ST_COAST;
          n.torque     = 1'b1;
          n.tof_active = 1'b1;
          ev[`IRQ_TORQUE] = 1'b1;
        end
      end
      ST_COAST:
      begin
        // Completion needs standstill and, with a brake, its completion delay.
        if (zero_spd && (!brake_en || tif.done[`TMR_COMPL]))
        begin
          n.st        = ST_STOPPED;
          n.completed = 1'b1;
          ev[`IRQ_DONE] = 1'b1;
        end
      end
      ST_STOPPED:
      begin
        // Acknowledge counts only after the request has been withdrawn.
        if (stop_ack && !stop_request)
        begin
          n.st         = ST_IDLE;
          n.torque     = 1'b0;
          n.brake      = 1'b0;
          n.active     = 1'b0;
          n.completed  = 1'b0;
          n.tof_active = 1'b0;
        end
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase

    // Sticky events: a new event wins over a clear in the same cycle.
    n.irq_st = (q.irq_st & ~clr) | ev;
    n.irq    = |(n.irq_st & n.irq_msk);

    // Ready flags follow the next holding state.
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.ctrl     <= `CTRL_RESET;
      q.cfg      <= {`CFG_N{`CFG_RESET}};
      q.irq_st   <= `IRQ_RESET;
      q.irq_msk  <= `IRQ_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready                = q.awready;
  assign s_axi_wready                 = q.wready;
  assign s_axi_bvalid                 = q.bvalid;
  assign s_axi_bresp                  = q.bresp;
  assign s_axi_arready                = q.arready;
  assign s_axi_rvalid                 = q.rvalid;
  assign s_axi_rdata                  = q.rdata;
  assign s_axi_rresp                  = q.rresp;
  assign safe_torque_removal          = q.torque;
  assign safe_brake_control           = q.brake;
  assign stop_active_indication       = q.active;
  assign stop_completed_indication    = q.completed;
  assign torque_off_active_indication = q.tof_active;
  assign stop_ramp_param_set          = q.cfg[`CFG_RAMP_PARAM][15:0];
  assign irq                          = q.irq;

endmodule : safe_stop_one_sequencer

// ---- safe_stop_one_params.svh ----
// Offsets, field positions, reset values and timer slots of the stop sequencer.
`ifndef SAFE_STOP_ONE_PARAMS_SVH
`define SAFE_STOP_ONE_PARAMS_SVH

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK   8'h0C
`define OFS_CFG_BASE   8'h10
`define OFS_CFG_LAST   8'h38

`define CFG_N          11
`define CFG_MAX_STOP   0
`define CFG_ZERO_LIM   1
`define CFG_ENC_ZERO   2
`define CFG_BRAKE_DLY  3
`define CFG_COMPL_DLY  4
`define CFG_EXTRA_DLY  5
`define CFG_INTER_SPD  6
`define CFG_RAMP_PARAM 7
`define CFG_RESP_TIME  8
`define CFG_RAMP_STEP  9
`define CFG_RAMP_TOL   10

`define CTRL_RAMP_MODE 0
`define CTRL_BRAKE_EN  1
`define CTRL_ENCODER   2
`define CTRL_INTER_EN  3
`define CTRL_W         4
`define CTRL_RESET     4'h0

`define IRQ_START      0
`define IRQ_TORQUE     1
`define IRQ_DONE       2
`define IRQ_FAULT      3
`define IRQ_W          4
`define IRQ_RESET      4'h0
`define CFG_RESET      32'h0000_0000

`define TMR_N          4
`define TMR_MAX        0
`define TMR_PHASE      1
`define TMR_COMPL      2
`define TMR_RESP       3

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ---- safe_stop_one_pkg.sv ----
// Types shared by the stop sequencer and its timer bank.
package safe_stop_one_pkg;
`include "safe_stop_one_params.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAMP,
    ST_EXTRA,
    ST_BRAKE,
    ST_COAST,
    ST_STOPPED
  } seq_state_t;

  typedef struct packed {
    logic [`TMR_N-1:0][31:0] cnt;
    logic [`TMR_N-1:0]       run;
    logic [`TMR_N-1:0]       done;
  } timer_state_t;

  typedef struct packed {
    seq_state_t                st;
    logic [`CTRL_W-1:0]        ctrl;
    logic [`CFG_N-1:0][31:0]   cfg;
    logic [`IRQ_W-1:0]         irq_st;
    logic [`IRQ_W-1:0]         irq_msk;
    logic                      irq;
    logic [31:0]               ramp_lim;
    logic                      ramp_run;
    logic                      fault;
    logic                      torque;
    logic                      brake;
    logic                      active;
    logic                      completed;
    logic                      tof_active;
    logic [7:0]                aw_addr;
    logic                      aw_got;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      w_got;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } seq_regs_t;

endpackage : safe_stop_one_pkg

// ---- delay_timer_if.sv ----
// Start, load and expiry signals between the sequencer and its timer bank.
`timescale 1ns/1ps
`include "safe_stop_one_params.svh"
interface delay_timer_if;
  import safe_stop_one_pkg::*;
  logic [`TMR_N-1:0]       start;
  logic [`TMR_N-1:0][31:0] load;
  logic [`TMR_N-1:0]       done;
  modport ctrl (output start, output load, input done);
  modport unit (input start, input load, output done);
endinterface : delay_timer_if

// ---- delay_timer_bank.sv ----
// Bank of down-counting delay timers with level expiry flags.
`timescale 1ns/1ps
`include "safe_stop_one_params.svh"
module delay_timer_bank (
  input wire logic        aclk,
  input wire logic        aresetn,
  delay_timer_if.unit     tif
);
  import safe_stop_one_pkg::*;

  timer_state_t q;
  timer_state_t n;

  // A start reloads a timer and clears its flag; the flag rises once the count runs out.
  always_comb
  begin
    n = q;
    for (int i = 0; i < `TMR_N; i++)
    begin
      if (tif.start[i])
      begin
        n.cnt[i]  = tif.load[i];
        n.run[i]  = 1'b1;
        n.done[i] = 1'b0;
      end
      else if (q.run[i] && q.cnt[i] == 32'h0000_0000)
      begin
        n.run[i]  = 1'b0;
        n.done[i] = 1'b1;
      end
      else if (q.run[i])
      begin
        n.cnt[i] = q.cnt[i] - 32'h0000_0001;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= n;
  end

  // Expiry flags come straight from the flip-flops.
  assign tif.done = q.done;

endmodule : delay_timer_bank

// ---- stop_seq_checker.sv ----
// Port-level assertions for the stop sequencer.
`timescale 1ns/1ps
module stop_seq_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        stop_request,
  input wire logic        stop_ack,
  input wire logic        safe_torque_removal,
  input wire logic        stop_active_indication,
  input wire logic        stop_completed_indication,
  input wire logic        torque_off_active_indication,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The stop sequence and its indications.
  AST_ACT_RISE: assert property ($rose(stop_active_indication) |-> $past(stop_request))
    else $error("active indication rose without a request");
  AST_ACT_HOLD: assert property (stop_active_indication && !stop_ack
    |=> stop_active_indication)
    else $error("active indication dropped without acknowledge");
  AST_TOF: assert property (safe_torque_removal |-> torque_off_active_indication)
    else $error("torque removed without torque-off indication");
  AST_TQ_IN_STOP: assert property ($rose(safe_torque_removal) |-> stop_active_indication)
    else $error("torque removed outside a stop");
  AST_DONE_ACT: assert property (stop_completed_indication |-> stop_active_indication)
    else $error("completed without active indication");
  AST_ACK_IGN: assert property (stop_completed_indication && stop_request
    |=> stop_completed_indication)
    else $error("acknowledge taken while request still high");
  AST_ACK_CLR: assert property (stop_completed_indication && !stop_request && stop_ack
    |=> !stop_active_indication && !stop_completed_indication && !safe_torque_removal
    && !torque_off_active_indication)
    else $error("acknowledge did not end the stop");
  AST_TQ_FALL: assert property ($fell(safe_torque_removal) |-> $past(stop_ack))
    else $error("torque restored without acknowledge");

  // Bus answers stand until taken.
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : stop_seq_checker

bind safe_stop_one_sequencer stop_seq_checker i_stop_seq_checker (.aclk, .aresetn, .stop_request,
  .stop_ack, .safe_torque_removal, .stop_active_indication, .stop_completed_indication,
  .torque_off_active_indication, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);

// ---- drive_model.sv ----
// Behavioural drive that ramps the motor down on a stop and coasts without torque.
`timescale 1ns/1ps
module drive_model #(
  parameter int RUN_SPEED = 40,
  parameter int OWN_STEP  = 4,
  parameter int RESP      = 3,
  parameter int COAST     = 2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        stop_active_indication,
  input  wire logic        safe_torque_removal,
  input  wire logic [15:0] stop_ramp_param_set,
  input  wire logic        stall,
  output logic [15:0]      motor_speed
);
  int          wait_q;
  logic [15:0] step;

  // A zero ramp setting selects the drive's own deceleration.
  assign step = (stop_ramp_param_set == 16'h0000) ? 16'(OWN_STEP) : stop_ramp_param_set;

  // Speed waits out the response time, then falls by one step a cycle unless stalled.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (!stop_active_indication && !safe_torque_removal))
    begin
      motor_speed <= 16'(RUN_SPEED);
      wait_q      <= 0;
    end
    else if (safe_torque_removal)
      motor_speed <= (motor_speed > 16'(COAST)) ? motor_speed - 16'(COAST) : 16'h0000;
    else if (wait_q < RESP)
      wait_q <= wait_q + 1;
    else if (!stall)
      motor_speed <= (motor_speed > step) ? motor_speed - step : 16'h0000;
  end
endmodule : drive_model

// ---- testbench.sv ----
// Self-checking bench for the stop sequencer and its register file.
`timescale 1ns/1ps
`include "safe_stop_one_params.svh"
`define CHECK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAIT(c) for (int k = 0; k < 600 && !(c); k++) @(posedge aclk);
module testbench;
  import safe_stop_one_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        stop_request = 1'b0, stop_ack = 1'b0, stall = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        safe_torque_removal, safe_brake_control, irq;
  logic        stop_active_indication, stop_completed_indication, torque_off_active_indication;
  logic [15:0] stop_ramp_param_set, motor_speed;
  int          n_fail = 0, n_checks = 0, cyc = 0, cnt, cnt0, nb;
  int          cv[`CFG_N] = '{200, 2, 0, 0, 0, 0, 0, 8, 3, 1, 4};

  safe_stop_one_sequencer i_safe_stop_one_sequencer (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_request, .stop_ack,
    .motor_speed, .safe_torque_removal, .safe_brake_control, .stop_active_indication,
    .stop_completed_indication, .torque_off_active_indication, .stop_ramp_param_set, .irq);

  drive_model i_drive_model (.aclk, .aresetn, .stop_active_indication, .safe_torque_removal,
    .stop_ramp_param_set, .stall, .motor_speed);

  // Clock and the hang guard.
  always #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // One AXI4-Lite write with the expected response code.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // Waits as long as the answer takes; only the hang guard ends a dead wait.
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    `CHECK(s_axi_bresp, er)
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // One AXI4-Lite read compared with the expected data and response.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    `CHECK(s_axi_rdata, e)
    `CHECK(s_axi_rresp, er)
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic set_cfg(input int i, input logic [31:0] v);
    axi_wr(8'(`OFS_CFG_BASE + 4 * i), v, `RESP_OKAY);
  endtask : set_cfg

  // Raises a request; n counts cycles from the trigger sample to torque removal and nb
  // those of them in which the brake already stood.
  task automatic start_stop(output int n, output int nb);
    stop_request <= 1'b1;
    `WAIT(stop_active_indication)
    `CHECK(stop_active_indication, 1'b1)
    `WAIT(motor_speed <= 16'h0002 || safe_brake_control || safe_torque_removal)
    n  = 0;
    nb = 0;
    while (!safe_torque_removal && n < 600)
    begin
      if (safe_brake_control)
        nb++;
      @(posedge aclk);
      n++;
    end
  endtask : start_stop

  // Waits for completion, tries a refused acknowledge, then the accepted one.
  task automatic end_stop();
    `WAIT(stop_completed_indication)
    `CHECK(stop_completed_indication, 1'b1)
    stop_ack <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHECK(stop_completed_indication, 1'b1)
    stop_request <= 1'b0;
    @(posedge aclk);
    stop_ack <= 1'b0;
    @(posedge aclk);
    `CHECK({stop_active_indication, stop_completed_indication, torque_off_active_indication,
      safe_torque_removal, safe_brake_control}, 5'h00)
  endtask : end_stop

  // Main sequence of tests.
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`OFS_CTRL, 32'(`CTRL_RESET), `RESP_OKAY);
    axi_rd(`OFS_IRQ_MASK, 32'(`IRQ_RESET), `RESP_OKAY);
    axi_rd(`OFS_CFG_BASE, `CFG_RESET, `RESP_OKAY);
    axi_rd(8'h40, 32'h0, `RESP_SLVERR);
    axi_wr(8'h40, 32'hFFFF_FFFF, `RESP_SLVERR);
    axi_wr(`OFS_STATUS, 32'h0000_00FF, `RESP_OKAY);
    axi_rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
    for (int i = 0; i < `CFG_N; i++)
      set_cfg(i, 32'(cv[i]));
    axi_rd(`OFS_CFG_LAST, 32'h4, `RESP_OKAY);
    axi_wr(`OFS_IRQ_MASK, 32'h5, `RESP_OKAY);
    $display("test registers done");
    // Normal time-supervised stops with the module's ramp and the drive's own ramp.
    for (int p = 8; p >= 0; p -= 8)
    begin
      set_cfg(`CFG_RAMP_PARAM, 32'(p));
      start_stop(cnt, nb);
      `CHECK(stop_ramp_param_set, 16'(p))
      `CHECK(motor_speed <= 16'h0002, 1'b1)
      `CHECK(torque_off_active_indication, 1'b1)
      `CHECK(irq, 1'b1)
      end_stop();
      axi_rd(`OFS_IRQ_STATUS, 32'h7, `RESP_OKAY);
      axi_wr(`OFS_IRQ_STATUS, 32'h7, `RESP_OKAY);
      axi_rd(`OFS_IRQ_STATUS, 32'h0, `RESP_OKAY);
      `CHECK(irq, 1'b0)
    end
    $display("test normal stop done");
    // Extra delay lengthens the way from zero speed to torque removal.
    for (int x = 0; x <= 5; x += 5)
    begin
      set_cfg(`CFG_EXTRA_DLY, 32'(x));
      start_stop(cnt, nb);
      if (x == 0)
        cnt0 = cnt;
      else
        `CHECK(cnt - cnt0, 5)
      end_stop();
    end
    set_cfg(`CFG_EXTRA_DLY, 32'h0);
    $display("test extra delay done");
    // A stalled drive trips the stop timer, then the ramp envelope.
    stall <= 1'b1;
    set_cfg(`CFG_MAX_STOP, 32'd30);
    for (int m = 0; m < 2; m++)
    begin
      axi_wr(`OFS_CTRL, 32'(m), `RESP_OKAY);
      if (m == 1)
        set_cfg(`CFG_MAX_STOP, 32'd400);
      start_stop(cnt, nb);
      `CHECK(safe_torque_removal, 1'b1)
      `CHECK(motor_speed > 16'h0002, 1'b1)
      end_stop();
    end
    stall <= 1'b0;
    $display("test supervision done");
    // Brake with zero and with negative delay.
    axi_wr(`OFS_CTRL, 32'h2, `RESP_OKAY);
    set_cfg(`CFG_COMPL_DLY, 32'd6);
    for (int b = 0; b < 2; b++)
    begin
      set_cfg(`CFG_BRAKE_DLY, b ? 32'hFFFF_FFFD : 32'h0);
      start_stop(cnt, nb);
      // The brake leads torque by the three-cycle delay, the timer's expiry edge and one step.
      `CHECK(nb, b ? 3 + 2 : 0)
      `CHECK(cnt - nb, cnt0)
      `CHECK(safe_brake_control, 1'b1)
      `CHECK(stop_completed_indication, 1'b0)
      // Completion trails braking by the six-cycle delay plus the same two cycles.
      cnt = 0;
      while (!stop_completed_indication && cnt < 600)
      begin
        @(posedge aclk);
        cnt++;
      end
      `CHECK(cnt + nb, 6 + 2)
      end_stop();
    end
    $display("test brake done");
    // Encoder limit ends the stop early; braking starts at an intermediate speed.
    set_cfg(`CFG_BRAKE_DLY, 32'h0);
    set_cfg(`CFG_ENC_ZERO, 32'd12);
    set_cfg(`CFG_INTER_SPD, 32'd32);
    axi_wr(`OFS_CTRL, 32'hE, `RESP_OKAY);
    start_stop(cnt, nb);
    `CHECK(motor_speed > 16'h0002, 1'b1)
    `WAIT(stop_completed_indication)
    `CHECK(motor_speed > 16'h0002, 1'b1)
    end_stop();
    $display("test encoder and intermediate speed done");
    conclude();
  end
endmodule : testbench
